// *** init_status_pkg.sv ***
// Package: offsets, fields, reset values and types for the init/status register bank
package init_status_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_ENGINE_STATUS  = 8'h00;
	localparam logic [7:0] OFF_HOST_BUS_INIT  = 8'h04;
	localparam logic [7:0] OFF_PROC_MONITOR   = 8'h08;
	localparam logic [7:0] OFF_TILE_APERTURE  = 8'h0c;
	localparam logic [7:0] OFF_MISC_INIT_A    = 8'h10;
	localparam logic [7:0] OFF_MISC_INIT_B    = 8'h14;
	localparam logic [7:0] OFF_MEMORY_INIT_A  = 8'h18;
	localparam logic [7:0] OFF_MEMORY_INIT_B  = 8'h1c;
	localparam logic [7:0] OFF_ACCEL_PORT     = 8'h20;
	localparam logic [7:0] OFF_TEX_CACHE      = 8'h24;
	localparam logic [7:0] OFF_LEGACY_DISP_A  = 8'h28;
	localparam logic [7:0] OFF_LEGACY_DISP_B  = 8'h2c;
	localparam logic [7:0] OFF_BLIT_COMMAND   = 8'h30;
	localparam logic [7:0] OFF_BLIT_SRC_BASE  = 8'h34;
	localparam logic [7:0] OFF_STRAP_READBACK = 8'h38;
	localparam logic [7:0] OFF_IMPEDANCE      = 8'h48;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_HOST_BUS_INIT = 32'h01800040;
	localparam logic [31:0] RST_PROC_MONITOR  = 32'h40000000;
	localparam logic [28:0] RST_TILE_CONTROL  = 29'h000a2200;
	localparam logic [28:0] RST_TILE_COMPARE  = 29'h00000000;
	localparam logic [31:0] RST_PLAIN         = 32'h00000000;

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int          HOST_FIFO_DEPTH   = 32;
	localparam logic [4:0]  FREE_WHEN_EMPTY   = 5'h1f;
	localparam logic [31:0] HBI_WRITE_MASK    = 32'h1fffffff;  // Bits 31:29 reserved
	localparam int          HBI_PRIO_BIT      = 26;
	localparam int          HBI_TIMEOUT_LO    = 27;
	localparam int          HBI_GROUP_LO      = 20;
	localparam int          PSM_CLR_N_BIT     = 28;
	localparam int          PSM_NOR_BIT       = 29;
	localparam int          PSM_EN_BIT        = 30;
	localparam int          TAC_RSEL_BIT      = 29;
	localparam int          TAC_UPD_ONLY_BIT  = 30;
	localparam int          TAC_WSEL_BIT      = 31;
	localparam logic [31:0] TILE_CTRL_MASK    = 32'h01ffffff;  // 28:25 reserved
	localparam logic [31:0] TILE_CMP_MASK     = 32'h0000ffff;  // 28:16 reserved

	// Flush timeout in memory clocks per encoding
	localparam logic [8:0] FLUSH_CLK_0 = 9'h040;  // 64
	localparam logic [8:0] FLUSH_CLK_1 = 9'h080;  // 128
	localparam logic [8:0] FLUSH_CLK_2 = 9'h0c4;  // 196
	localparam logic [8:0] FLUSH_CLK_3 = 9'h100;  // 256

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic        write;   // One-cycle write strobe
		logic        read;    // One-cycle read strobe
		logic [7:0]  addr;    // Byte address
		logic [31:0] wdata;   // Write data
	} reg_req_t;

	typedef struct packed {
		logic [4:0] host_fifo_free;   // Free entries in host FIFO
		logic       host_fifo_busy;   // Host FIFO busy
		logic       vretrace_active;  // Monitor retrace active
		logic       render_busy;      // Pixel render engine busy
		logic       texture_busy;     // Texture unit incl. FIFOs busy
		logic       other_busy;       // Any other internal unit busy
		logic       blit_busy;        // 2D engine busy
		logic [1:0] cmd_fifo_busy;    // Command FIFOs 1:0 busy
		logic [1:0] tex_unit_busy;    // Texture mapping units 1:0 busy
	} engine_state_t;

	typedef struct packed {
		logic       high_priority;    // Host/command fb accesses high priority
		logic [5:0] group_count;      // Accesses grouped before push
		logic [8:0] flush_clocks;     // Memory clocks before flush
		logic [4:0] low_water;        // Host FIFO low-water mark
	} bus_tuning_t;

endpackage : init_status_pkg

// *** init_status_config_regs.sv ***
// Init and status register bank behind the host register port
`timescale 1ns/100ps
// What this block does
// - Status write clears interrupts, data ignored
// - Bits 4:0 free entries, bit 5 busy
// - Bit 6 low during retrace, resets 1
// - Bit 7 render engine busy only
// - Bit 8 whole texture unit busy
// - Bit 9 any unit active
// - Bits 14:10 2D, cmd fifos, texture units busy
// - Bits 30:28 count pending buffer swaps
// - Retrace interrupt sets bit 31, interrupt line
// - Host bus init RW, resets 0x01800040
// - Bits 28:27 choose flush timeout clocks
// - Bits 25:20 access grouping count, default 0x18
// - Bit 26 raises host/command memory priority
// - Monitor: reference count, oscillator count fields
// - Monitor: clear_n, ring select, enable bits
// - Monitor RW, resets 0x40000000
// - Tile write: selector 0 control, 2 compare
// - Tile read: select, then read back
// - Bit 30 write updates only read select
// - Stored bit 29 picks read register
module init_status_config_regs #(
	parameter int FREE_W = 5              // Width of free-space field
) (
	input  wire logic                          sys_clk_i,        // 100 MHz graphics clock
	input  wire logic                          rst_i,            // Sync reset, active high
	input  wire init_status_pkg::reg_req_t     req_i,            // Register access
	output logic [31:0]                        rdata_o,          // Read data, registered
	output logic                               rvalid_o,         // Read data valid pulse
	input  wire init_status_pkg::engine_state_t state_i,         // Engine activity flags
	input  wire logic                          retrace_irq_i,    // Retrace interrupt event
	input  wire logic                          swap_arrive_i,    // Swap command received
	input  wire logic                          swap_done_i,      // Swap completed
	input  wire logic                          ring_tick_i,      // Ring oscillator edge pulse
	output logic                               host_irq_o,       // Interrupt to host
	output logic                               ring_nor_sel_o,   // Ring select 0 nand 1 nor
	output logic                               ring_enable_o,    // Ring oscillator enable
	output init_status_pkg::bus_tuning_t       tuning_o,         // Decoded host bus tuning
	output logic [28:0]                        tile_control_o,   // Tile control value
	output logic [28:0]                        tile_compare_o    // Tile compare value
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [31:0] host_bus_init_q;    // Host bus tuning register
	logic [31:0] monitor_ctrl_q;     // Monitor control bits 30:28
	logic [15:0] ref_count_q;        // Reference counter
	logic [11:0] osc_count_q;        // Oscillator-driven counter
	logic [28:0] tile_control_q;     // Tile control
	logic [28:0] tile_compare_q;     // Tile compare
	logic        tile_rsel_q;        // Read select bit
	logic [2:0]  swap_pend_q;        // Pending swaps
	logic        irq_q;              // Interrupt flag
	logic [31:0] plain_q [0:11];     // Plain init registers, indexed; entries 8 and 9 write-only
	logic [31:0] rdata_q;            // Read data flop
	logic        rvalid_q;           // Read valid flop
	logic [31:0] status_w;           // Assembled status word

	// Write strobe for a given offset
	function automatic logic wr_hit(input logic [7:0] off);
		return req_i.write && (req_i.addr == off);
	endfunction : wr_hit

	// Index of a plain register, 4'hf when none
	function automatic logic [3:0] plain_index(input logic [7:0] a);
		unique case (a)
			init_status_pkg::OFF_MISC_INIT_A:    return 4'h0;
			init_status_pkg::OFF_MISC_INIT_B:    return 4'h1;
			init_status_pkg::OFF_MEMORY_INIT_A:  return 4'h2;
			init_status_pkg::OFF_MEMORY_INIT_B:  return 4'h3;
			init_status_pkg::OFF_ACCEL_PORT:     return 4'h4;
			init_status_pkg::OFF_TEX_CACHE:      return 4'h5;
			init_status_pkg::OFF_LEGACY_DISP_A:  return 4'h6;
			init_status_pkg::OFF_LEGACY_DISP_B:  return 4'h7;
			init_status_pkg::OFF_BLIT_COMMAND:   return 4'h8;
			init_status_pkg::OFF_BLIT_SRC_BASE:  return 4'h9;
			init_status_pkg::OFF_STRAP_READBACK: return 4'ha;
			init_status_pkg::OFF_IMPEDANCE:      return 4'hb;
			default:                             return 4'hf;
		endcase
	endfunction : plain_index

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	// Live flags plus the swap_pend_q and irq_q flops; reserved 27:15 forced low
	always_comb begin
		status_w        = 32'h00000000;
		status_w[FREE_W-1:0] = state_i.host_fifo_free;
		status_w[5]     = state_i.host_fifo_busy;
		status_w[6]     = ~state_i.vretrace_active;
		status_w[7]     = state_i.render_busy;
		status_w[8]     = state_i.texture_busy;
		// Any activity anywhere, including FIFO occupancy
		status_w[9]     = state_i.render_busy | state_i.texture_busy
			| state_i.host_fifo_busy | state_i.blit_busy
			| (|state_i.cmd_fifo_busy) | (|state_i.tex_unit_busy)
			| state_i.other_busy
			| (state_i.host_fifo_free != init_status_pkg::FREE_WHEN_EMPTY);
		status_w[10]    = state_i.blit_busy;
		status_w[12:11] = state_i.cmd_fifo_busy;
		status_w[14:13] = state_i.tex_unit_busy;
		status_w[30:28] = swap_pend_q;
		status_w[31]    = irq_q;
	end

	// ------------------------------------------------------------
	// Interrupt flag
	// ------------------------------------------------------------
	// A new event in the clearing cycle wins, so none is lost
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else if (retrace_irq_i) begin
			irq_q <= 1'b1;
		end else if (wr_hit(init_status_pkg::OFF_ENGINE_STATUS)) begin
			irq_q <= 1'b0;
		end
	end

	assign host_irq_o = irq_q;

	// ------------------------------------------------------------
	// Swap pending counter
	// ------------------------------------------------------------
	// Simultaneous arrive and done cancel; saturates at both ends
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			swap_pend_q <= 3'h0;
		end else if (swap_arrive_i && !swap_done_i && swap_pend_q != 3'h7) begin
			swap_pend_q <= swap_pend_q + 3'h1;
		end else if (swap_done_i && !swap_arrive_i && swap_pend_q != 3'h0) begin
			swap_pend_q <= swap_pend_q - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Host bus init register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			host_bus_init_q <= init_status_pkg::RST_HOST_BUS_INIT;
		end else if (wr_hit(init_status_pkg::OFF_HOST_BUS_INIT)) begin
			// Low-water value taken as written; keeping it sane is software's job
			host_bus_init_q <= req_i.wdata & init_status_pkg::HBI_WRITE_MASK;
		end
	end

	// Decoded tuning outputs
	always_comb begin
		tuning_o.high_priority = host_bus_init_q[init_status_pkg::HBI_PRIO_BIT];
		tuning_o.group_count   = host_bus_init_q[init_status_pkg::HBI_GROUP_LO +: 6];
		tuning_o.low_water     = host_bus_init_q[6:2];
		unique case (host_bus_init_q[init_status_pkg::HBI_TIMEOUT_LO +: 2])
			2'h0: tuning_o.flush_clocks = init_status_pkg::FLUSH_CLK_0;
			2'h1: tuning_o.flush_clocks = init_status_pkg::FLUSH_CLK_1;
			2'h2: tuning_o.flush_clocks = init_status_pkg::FLUSH_CLK_2;
			2'h3: tuning_o.flush_clocks = init_status_pkg::FLUSH_CLK_3;
		endcase
	end

	// ------------------------------------------------------------
	// Process speed monitor
	// ------------------------------------------------------------
	// Control bits only; counter fields are read-only
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			monitor_ctrl_q <= init_status_pkg::RST_PROC_MONITOR;
		end else if (wr_hit(init_status_pkg::OFF_PROC_MONITOR)) begin
			monitor_ctrl_q <= {1'b0, req_i.wdata[30:28], 28'h0000000};
		end
	end

	// Reference counter on the graphics clock, counts while enabled
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ref_count_q <= 16'h0000;
		end else if (monitor_ctrl_q[init_status_pkg::PSM_EN_BIT]) begin
			ref_count_q <= ref_count_q + 16'h0001;
		end
	end

	// Oscillator counter; the ring edge arrives already as a pulse here
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			osc_count_q <= 12'h000;
		end else if (!monitor_ctrl_q[init_status_pkg::PSM_CLR_N_BIT]) begin
			osc_count_q <= 12'h000;
		end else if (monitor_ctrl_q[init_status_pkg::PSM_EN_BIT] && ring_tick_i) begin
			osc_count_q <= osc_count_q + 12'h001;
		end
	end

	assign ring_nor_sel_o = monitor_ctrl_q[init_status_pkg::PSM_NOR_BIT];
	assign ring_enable_o  = monitor_ctrl_q[init_status_pkg::PSM_EN_BIT];

	// ------------------------------------------------------------
	// Tile aperture pair
	// ------------------------------------------------------------
	// Bit 30 set: only the read select moves
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tile_rsel_q <= 1'b0;
		end else if (wr_hit(init_status_pkg::OFF_TILE_APERTURE)
				&& req_i.wdata[init_status_pkg::TAC_UPD_ONLY_BIT]) begin
			tile_rsel_q <= req_i.wdata[init_status_pkg::TAC_RSEL_BIT];
		end
	end

	// Bit 31 picks which of the pair a data write lands in
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tile_control_q <= init_status_pkg::RST_TILE_CONTROL;
			tile_compare_q <= init_status_pkg::RST_TILE_COMPARE;
		end else if (wr_hit(init_status_pkg::OFF_TILE_APERTURE)
				&& !req_i.wdata[init_status_pkg::TAC_UPD_ONLY_BIT]) begin
			if (!req_i.wdata[init_status_pkg::TAC_WSEL_BIT]) begin
				tile_control_q <= req_i.wdata[28:0]
					& init_status_pkg::TILE_CTRL_MASK[28:0];
			end else begin
				tile_compare_q <= req_i.wdata[28:0]
					& init_status_pkg::TILE_CMP_MASK[28:0];
			end
		end
	end

	assign tile_control_o = tile_control_q;
	assign tile_compare_o = tile_compare_q;

	// ------------------------------------------------------------
	// Plain init registers
	// ------------------------------------------------------------
	// Stored as written; their fields belong to other blocks
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 12; i++) begin
				plain_q[i] <= init_status_pkg::RST_PLAIN;
			end
		end else if (req_i.write && plain_index(req_i.addr) != 4'hf) begin
			plain_q[plain_index(req_i.addr)] <= req_i.wdata;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// One cycle of latency; unmapped and write-only offsets read zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_q  <= 32'h00000000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req_i.read;
			if (req_i.read) begin
				unique case (req_i.addr)
					init_status_pkg::OFF_ENGINE_STATUS: rdata_q <= status_w;
					init_status_pkg::OFF_HOST_BUS_INIT: rdata_q <= host_bus_init_q;
					init_status_pkg::OFF_PROC_MONITOR:
						rdata_q <= monitor_ctrl_q | {4'h0, osc_count_q, ref_count_q};
					init_status_pkg::OFF_TILE_APERTURE:
						rdata_q <= tile_rsel_q ? {3'h0, tile_compare_q}
							: {3'h0, tile_control_q};
					init_status_pkg::OFF_BLIT_COMMAND,
					init_status_pkg::OFF_BLIT_SRC_BASE:  rdata_q <= 32'h00000000;
					default: begin
						if (plain_index(req_i.addr) != 4'hf) begin
							rdata_q <= plain_q[plain_index(req_i.addr)];
						end else begin
							rdata_q <= 32'h00000000;
						end
					end
				endcase
			end
		end
	end

	assign rdata_o  = rdata_q;
	assign rvalid_o = rvalid_q;

endmodule : init_status_config_regs

// *** init_status_config_regs_asserts.sv ***
// Checker: port-level properties of the init/status register bank
`timescale 1ns/100ps
module init_status_config_regs_asserts #(
	parameter int FREE_W = 5                                 // Free-space width
) (
	input  wire logic                           sys_clk_i,      // Clock
	input  wire logic                           rst_i,          // Sync reset
	input  wire init_status_pkg::reg_req_t      req_i,          // Request
	input  wire logic [31:0]                    rdata_o,        // Read data
	input  wire init_status_pkg::engine_state_t state_i,        // Activity
	input  wire logic                           retrace_irq_i,  // Irq event
	input  wire logic                           host_irq_o,     // Irq line
	input  wire logic                           ring_nor_sel_o, // Ring select
	input  wire logic                           ring_enable_o,  // Ring enable
	input  wire init_status_pkg::bus_tuning_t   tuning_o,       // Tuning
	input  wire logic [28:0]                    tile_control_o, // Tile control
	input  wire logic [28:0]                    tile_compare_o  // Tile compare
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	init_status_pkg::engine_state_t st_q;                    // State at read edge
	wire st_rd = req_i.read && req_i.addr == 8'h00;          // Status read
	wire hb_wr = req_i.write && req_i.addr == 8'h04;         // Bus init write
	wire tl_wr = req_i.write && req_i.addr == 8'h0c;         // Tile write
	wire tl_rd = req_i.read && !req_i.write && req_i.addr == 8'h0c;
	// Status is sampled at the read edge, so keep a copy
	always_ff @(posedge sys_clk_i) begin
		st_q <= state_i;
	end
	// Select write, idle cycle, then read of the shared address
	sequence sel_s(logic [1:0] s);
		tl_wr && req_i.wdata[30:29] == s ##1 !req_i.write ##1 tl_rd;
	endsequence
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	irq_set_a: assert property (retrace_irq_i |=> host_irq_o)
		else $error("irq not raised");
	irq_clear_a: assert property (req_i.write && req_i.addr == 8'h00 && !retrace_irq_i |=> !host_irq_o)
		else $error("irq not cleared");
	st_low_a: assert property (st_rd |=> rdata_o[8:0] == {st_q.texture_busy, st_q.render_busy,
		!st_q.vretrace_active, st_q.host_fifo_busy, st_q.host_fifo_free}) else $error("status low bad");
	st_flags_a: assert property (st_rd |=> rdata_o[14:10] == {st_q.tex_unit_busy, st_q.cmd_fifo_busy, st_q.blit_busy})
		else $error("busy flags bad");
	st_any_a: assert property (st_rd |=> rdata_o[9] == (|{st_q[9], st_q[7:0]} || st_q[14:10] != 5'h1f))
		else $error("any busy bad");
	tune_wr_a: assert property (hb_wr |=> tuning_o.group_count == $past(req_i.wdata[25:20])
		&& tuning_o.high_priority == $past(req_i.wdata[26])) else $error("tuning bad");
	flush_sel_a: assert property (hb_wr && req_i.wdata[28:27] == 2'h2 |=> tuning_o.flush_clocks == 9'h0c4)
		else $error("flush bad");
	ring_ctl_a: assert property (req_i.write && req_i.addr == 8'h08 |=> ring_enable_o == $past(req_i.wdata[30])
		&& ring_nor_sel_o == $past(req_i.wdata[29])) else $error("ring ctl bad");
	tile_keep_a: assert property (tl_wr && req_i.wdata[30] |=> $stable(tile_control_o) && $stable(tile_compare_o))
		else $error("tile changed");
	tile_ctl_a: assert property (tl_wr && req_i.wdata[31:30] == 2'h0 |=> tile_control_o == ($past(req_i.wdata[28:0]) & 29'h1ffffff))
		else $error("tile ctl bad");
	tile_cmp_a: assert property (tl_wr && req_i.wdata[31:30] == 2'h2 |=> tile_compare_o == ($past(req_i.wdata[28:0]) & 29'hffff))
		else $error("tile cmp bad");
	sel_cmp_a: assert property (sel_s(2'h3) |=> rdata_o == {3'h0, tile_compare_o})
		else $error("cmp readback bad");
	sel_ctl_a: assert property (sel_s(2'h2) |=> rdata_o == {3'h0, tile_control_o})
		else $error("ctl readback bad");
endmodule : init_status_config_regs_asserts

bind init_status_config_regs init_status_config_regs_asserts #(.FREE_W(FREE_W)) u_chk (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .state_i(state_i),
	.retrace_irq_i(retrace_irq_i), .host_irq_o(host_irq_o), .ring_nor_sel_o(ring_nor_sel_o),
	.ring_enable_o(ring_enable_o), .tuning_o(tuning_o), .tile_control_o(tile_control_o),
	.tile_compare_o(tile_compare_o));

// *** host_model.sv ***
// Host CPU model: register writes and reads on the request port
`timescale 1ns/100ps
module host_model (
	input  wire logic                 sys_clk_i, // Clock
	input  wire logic [31:0]          rdata_i,   // Read data
	input  wire logic                 rvalid_i,  // Read valid
	output init_status_pkg::reg_req_t req_o      // Request
);
	initial req_o = '0;
	// One-cycle write strobe, launched after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i) req_o <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk_i) req_o.write <= 1'b0;
	endtask : wr
	// Read; a missing answer returns unknowns so the compare fails
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i) req_o <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge sys_clk_i) req_o.read <= 1'b0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (rvalid_i !== 1'b1 && n < 4);
		d = (rvalid_i === 1'b1) ? rdata_i : 'x;
	endtask : rd
	// Bus init value that software may legally program
	function automatic logic [31:0] legal_hbi(input logic [31:0] v);
		legal_hbi = v | 32'h300;                     // Snoop-safe setting
		if (v[6:2] < 5'h3) legal_hbi[6:2] = 5'h3;    // Low-water above two
	endfunction : legal_hbi
	// Tile write: bit 31 picks control or compare
	task automatic tile_wr(input logic sel, input logic [28:0] d);
		wr(8'h0c, {sel, 2'b00, d});
	endtask : tile_wr
	// Tile read: select first, then read the shared address
	task automatic tile_rd(input logic sel, output logic [31:0] d);
		wr(8'h0c, {2'b01, sel, 29'h0});
		rd(8'h0c, d);
	endtask : tile_rd
endmodule : host_model

// *** testbench.sv ***
// Self-checking bench for the init/status register bank
`timescale 1ns/100ps
module testbench;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	logic sys_clk_i = 1'b0, rst_i = 1'b1;               // Clock, reset
	logic retrace_irq_i = 1'b0, ring_tick_i = 1'b0;      // Event pulses
	logic swap_arrive_i = 1'b0, swap_done_i = 1'b0;      // Swap pulses
	init_status_pkg::engine_state_t state_i = 15'h7c00;  // Idle, fifo empty
	init_status_pkg::reg_req_t      req;                 // From host model
	init_status_pkg::bus_tuning_t   tuning_o;            // Decoded tuning
	logic [31:0] rdata_o, rd_v, exp_q[$];                // Reads, expected queue
	logic rvalid_o, host_irq_o, ring_nor_sel_o, ring_enable_o;
	logic [28:0] tile_control_o, tile_compare_o;
	logic m_irq = 1'b0;                                  // Model irq flag
	int   m_swap = 0, err_count = 0, samples_checked = 0, cyc = 0;
	logic [7:0] rw_a [10] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h38, 8'h48};
	logic [7:0] z_a [3] = '{8'h30, 8'h34, 8'h3c};       // Write-only, unmapped
	logic [8:0] fl [4] = '{9'h040, 9'h080, 9'h0c4, 9'h100}; // Flush clocks

	init_status_config_regs i_init_status_config_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .state_i(state_i),
		.retrace_irq_i(retrace_irq_i), .swap_arrive_i(swap_arrive_i), .swap_done_i(swap_done_i),
		.ring_tick_i(ring_tick_i), .host_irq_o(host_irq_o), .ring_nor_sel_o(ring_nor_sel_o),
		.ring_enable_o(ring_enable_o), .tuning_o(tuning_o), .tile_control_o(tile_control_o),
		.tile_compare_o(tile_compare_o));
	host_model i_host_model (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req));

	initial forever #5 sys_clk_i = ~sys_clk_i;

	// ------------------------------------------------------------
	// Model and compare tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] m_status();
		logic b;
		b = |{state_i[9], state_i[7:0]} || state_i.host_fifo_free != 5'h1f;
		m_status = {m_irq, 3'(m_swap), 13'h0, state_i.tex_unit_busy, state_i.cmd_fifo_busy,
			state_i.blit_busy, b, state_i.texture_busy, state_i.render_busy,
			!state_i.vretrace_active, state_i.host_fifo_busy, state_i.host_fifo_free};
	endfunction : m_status
	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t read got=%h exp=%h", $time, g, e);
		end
	endtask : chk_rd
	task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t port got=%h exp=%h", $time, g, e);
		end
	endtask : chk_out
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		i_host_model.rd(a, rd_v);
		chk_rd(rd_v, e);
	endtask : rdc
	// Swap pulses; the model count saturates at 0 and 7
	task automatic swp(input logic a, input logic d);
		@(posedge sys_clk_i) {swap_arrive_i, swap_done_i} <= {a, d};
		@(posedge sys_clk_i) {swap_arrive_i, swap_done_i} <= 2'b00;
		if (a && !d && m_swap < 7) m_swap++;
		if (d && !a && m_swap > 0) m_swap--;
	endtask : swp
	task automatic end_sim();
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v, r1;
		logic [14:0] rnd;
		int n;
		void'($urandom(11));
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rdc(8'h00, m_status());
		rdc(8'h04, 32'h01800040);
		i_host_model.rd(8'h08, rd_v);
		chk_rd(rd_v & 32'hffff0000, 32'h40000000);
		chk_out(32'(tile_compare_o), 32'h0);
		chk_out(32'(tile_control_o), 32'h0a2200);
		// Plain registers: reset zero, then random write-back through a queue
		foreach (rw_a[i]) begin
			rdc(rw_a[i], 32'h0);
			v = $urandom;
			i_host_model.wr(rw_a[i], v);
			exp_q.push_back(v);
		end
		foreach (rw_a[i]) rdc(rw_a[i], exp_q.pop_front());
		foreach (z_a[i]) begin
			i_host_model.wr(z_a[i], $urandom);
			rdc(z_a[i], 32'h0);
		end
		// Random engine activity
		repeat (8) begin
			rnd = 15'($urandom);
			@(posedge sys_clk_i) state_i <= rnd;
			@(negedge sys_clk_i);
			rdc(8'h00, m_status());
		end
		// Interrupt raise and clear; written data is ignored
		@(posedge sys_clk_i) retrace_irq_i <= 1'b1;
		@(posedge sys_clk_i) retrace_irq_i <= 1'b0;
		m_irq = 1'b1;
		@(negedge sys_clk_i) chk_out(32'(host_irq_o), 32'h1);
		rdc(8'h00, m_status());
		i_host_model.wr(8'h00, 32'hffffffff);
		m_irq = 1'b0;
		rdc(8'h00, m_status());
		chk_out(32'(host_irq_o), 32'h0);
		// Swap count past its top, down, then both at once
		repeat (9) swp(1'b1, 1'b0);
		rdc(8'h00, m_status());
		repeat (2) swp(1'b0, 1'b1);
		swp(1'b1, 1'b1);
		rdc(8'h00, m_status());
		// Bus tuning for every flush encoding
		for (int k = 0; k < 4; k++) begin
			v = i_host_model.legal_hbi({$urandom} & 32'he7ffffff | (k << 27));
			i_host_model.wr(8'h04, v);
			rdc(8'h04, v & 32'h1fffffff);
			chk_out(32'(tuning_o), {11'h0, v[26], v[25:20], fl[k], v[6:2]});
		end
		// Oscillator ticks and reference counter
		i_host_model.wr(8'h08, 32'h70000000);
		n = 5 + $urandom_range(20, 0);
		@(posedge sys_clk_i) ring_tick_i <= 1'b1;
		repeat (n - 1) @(posedge sys_clk_i);
		@(posedge sys_clk_i) ring_tick_i <= 1'b0;
		i_host_model.rd(8'h08, r1);
		chk_rd(r1 & 32'hffff0000, 32'h70000000 | (n << 16));
		chk_out({ring_nor_sel_o, ring_enable_o}, 32'h3);
		i_host_model.rd(8'h08, rd_v);
		chk_rd(32'(rd_v[15:0] - r1[15:0]), 32'h2);
		i_host_model.wr(8'h08, 32'h0);
		i_host_model.rd(8'h08, r1);
		rdc(8'h08, r1);
		chk_rd(r1 & 32'hffff0000, 32'h0);
		// Shared tile address
		v = $urandom;
		i_host_model.tile_wr(1'b0, v[28:0]);
		r1 = $urandom;
		i_host_model.tile_wr(1'b1, r1[28:0]);
		i_host_model.tile_rd(1'b1, rd_v);
		chk_rd(rd_v, r1 & 32'hffff);
		i_host_model.tile_rd(1'b0, rd_v);
		chk_rd(rd_v, v & 32'h1ffffff);
		i_host_model.wr(8'h0c, 32'h7fffffff);
		rdc(8'h0c, r1 & 32'hffff);
		chk_out(32'(tile_control_o), v & 32'h1ffffff);
		end_sim();
	end
endmodule : testbench
